// ---- hdl/cfa_flags.sv ----
// Condition-flag generation datapath with registered flags and result
// Functional notes
// - Zero flag set for all-zero result, cleared otherwise.
// - Overflow flag set on signed arithmetic overflow, else cleared.
// - Carry flag takes carry out of the MSB on additions.
// - Carry flag set on borrow for subtractions, cleared otherwise.
// - Carry flag takes bit shifted or rotated out.
// - Carry flag is the accumulator for single-bit operations.
// - Operands are bits, BCD digits, bytes, words and longwords.
// - Bit operations pick bit 0..7 of a byte only.
// - Decimal adjust sees a byte as two packed BCD digits.
// - Odd word or longword address has bit 0 forced to zero.
// - Odd-addressed word or longword access raises no error.
// - Instruction fetches are aligned the same way.
// - Half carry from bit 3, 11 or 27 by size.
// - Negative flag copies the result's MSB.
// - Reset sets interrupt mask bit; other flags stay undefined.
// - Flags not affected by an operation keep their value.
`timescale 1ns/100ps
`default_nettype none
module cfa_flags
  import cfa_pkg::*;
#(
  parameter int ADDR_W = CFA_ADDR_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Operation
  input wire logic op_valid_in,
  input wire cfa_op_t op_in,
  input wire cfa_size_t size_in,
  input wire logic [31:0] opa_in,
  input wire logic [31:0] opb_in,
  input wire logic [CFA_BIDX_W-1:0] bit_idx_in,
  input wire logic [CFA_CCR_W-1:0] ccr_wdata_in,
  // Memory address alignment
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire cfa_size_t mem_size_in,
  input wire logic mem_fetch_in,
  output logic [ADDR_W-1:0] mem_addr_out,
  // Results
  output logic [31:0] result_out,
  output logic [CFA_CCR_W-1:0] condition_flags_out,
  output logic [31:0] mem_bytes_out
);
  typedef struct packed {
    logic [CFA_CCR_W-1:0] flags;
    logic [31:0] result;
  } cfa_state_t;

  cfa_state_t state_ff;
  cfa_state_t nxt_state;

  function automatic int unsigned msb_of(input cfa_size_t sz);
    unique case (sz)
      CFA_SZ_BYTE: msb_of = 7;
      CFA_SZ_WORD: msb_of = 15;
      default: msb_of = 31;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input cfa_size_t sz);
    unique case (sz)
      CFA_SZ_BYTE: size_mask = 32'h0000_00FF;
      CFA_SZ_WORD: size_mask = 32'h0000_FFFF;
      default: size_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  // Half-carry boundary per size
  function automatic int unsigned hc_of(input cfa_size_t sz);
    unique case (sz)
      CFA_SZ_BYTE: hc_of = CFA_HC_B;
      CFA_SZ_WORD: hc_of = CFA_HC_W;
      default: hc_of = CFA_HC_L;
    endcase
  endfunction

  cfa_align #(.ADDR_W(ADDR_W)) u_align (
    .addr_in(mem_addr_in),
    .size_in(mem_size_in),
    .fetch_in(mem_fetch_in),
    .addr_out(mem_addr_out)
  );

  always_comb begin
    logic [32:0] sum;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] res;
    logic [31:0] cin_bits;
    logic sub;
    logic cin;
    logic arith;
    logic logic_op;
    logic c_out;
    logic hc;
    int unsigned m;
    logic [7:0] adj;
    sum = '0;
    a = '0;
    b = '0;
    res = '0;
    cin_bits = '0;
    sub = 1'b0;
    cin = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    c_out = 1'b0;
    hc = 1'b0;
    m = msb_of(size_in);
    adj = '0;
    nxt_state = state_ff;
    if (op_valid_in) begin
      a = opa_in & size_mask(size_in);
      b = opb_in & size_mask(size_in);
      unique case (op_in)
        CFA_OP_ADD, CFA_OP_ADDX, CFA_OP_SUB, CFA_OP_SUBX: begin
          sub = (op_in == CFA_OP_SUB) || (op_in == CFA_OP_SUBX);
          cin = ((op_in == CFA_OP_ADDX) || (op_in == CFA_OP_SUBX)) &&
            state_ff.flags[CFA_BIT_C];
          // Subtract as a + ~b + 1 - cin; borrow is inverted carry
          if (sub) begin
            sum = {1'b0, a} + {1'b0, ~b & size_mask(size_in)} + 33'({1'b0, ~cin});
          end else begin
            sum = {1'b0, a} + {1'b0, b} + 33'(cin);
          end
          res = sum[31:0] & size_mask(size_in);
          cin_bits = a ^ (sub ? ~b : b) ^ sum[31:0];
          c_out = sum[m+1] ^ sub;
          hc = cin_bits[hc_of(size_in)+1] ^ sub;
          arith = 1'b1;
          nxt_state.flags[CFA_BIT_C] = c_out;
          nxt_state.flags[CFA_BIT_H] = hc;
          // Same-sign inputs giving other-sign result
          nxt_state.flags[CFA_BIT_V] = (a[m] == (sub ? ~b[m] : b[m])) && (res[m] != a[m]);
        end
        CFA_OP_AND: begin
          res = a & b;
          logic_op = 1'b1;
        end
        CFA_OP_SHL, CFA_OP_ROTL: begin
          res = ((a << 1) | ((op_in == CFA_OP_ROTL) ? 32'(a[m]) : '0)) & size_mask(size_in);
          nxt_state.flags[CFA_BIT_C] = a[m];
          logic_op = 1'b1;
        end
        CFA_OP_SHR, CFA_OP_ROTR: begin
          res = (a >> 1) | ((op_in == CFA_OP_ROTR) ? (32'(a[0]) << m) : '0);
          nxt_state.flags[CFA_BIT_C] = a[0];
          logic_op = 1'b1;
        end
        // Bit operations touch only bit 0..7 of a byte
        CFA_OP_BLD: begin
          res = opa_in;
          nxt_state.flags[CFA_BIT_C] = opa_in[bit_idx_in];
        end
        CFA_OP_BAND: begin
          res = opa_in;
          nxt_state.flags[CFA_BIT_C] = state_ff.flags[CFA_BIT_C] & opa_in[bit_idx_in];
        end
        CFA_OP_BST: begin
          res = opa_in;
          res[bit_idx_in] = state_ff.flags[CFA_BIT_C];
        end
        // Packed BCD digits, adjust from C and H
        CFA_OP_DAA, CFA_OP_DAS: begin
          if (state_ff.flags[CFA_BIT_H] ||
              ({4'h0, opa_in[CFA_NIB_W-1:0]} > CFA_NIB_LIMIT)) begin
            adj = adj | CFA_DEC_ADJ_LO;
          end
          if (state_ff.flags[CFA_BIT_C] ||
              ({4'h0, opa_in[2*CFA_NIB_W-1:CFA_NIB_W]} > CFA_NIB_LIMIT)) begin
            adj = adj | CFA_DEC_ADJ_HI;
          end
          res = {24'h0, (op_in == CFA_OP_DAA) ? opa_in[7:0] + adj : opa_in[7:0] - adj};
          // A high-digit adjust is the decimal carry or borrow
          nxt_state.flags[CFA_BIT_C] = state_ff.flags[CFA_BIT_C] | ((adj & CFA_DEC_ADJ_HI) != '0);
          logic_op = 1'b1;
        end
        CFA_OP_LDC: begin
          nxt_state.flags = ccr_wdata_in;
        end
        CFA_OP_NONE: begin
          // No flag affected
          res = state_ff.result;
        end
      endcase
      if (arith || logic_op) begin
        nxt_state.flags[CFA_BIT_Z] = (res == '0);
        nxt_state.flags[CFA_BIT_N] = res[m];
      end
      if (logic_op) begin
        nxt_state.flags[CFA_BIT_V] = 1'b0;
      end
      nxt_state.result = res;
    end
  end

  // Only the mask bit has a reset value; flags stay as they were
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff.flags[CFA_BIT_I] <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign result_out = state_ff.result;
  assign condition_flags_out = state_ff.flags;
  // Big-endian lane order for memory writes
  always_comb begin
    unique case (size_in)
      CFA_SZ_BYTE: mem_bytes_out = {state_ff.result[7:0], 24'h0};
      CFA_SZ_WORD: mem_bytes_out = {state_ff.result[15:0], 16'h0};
      default: mem_bytes_out = state_ff.result;
    endcase
  end

  flag_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_AND && ((opa_in & opb_in & size_mask(size_in)) == '0)
    |=> condition_flags_out[CFA_BIT_Z]) else $error("zero flag not set");
  carry_add_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_ADD && size_in == CFA_SZ_BYTE
    |=> condition_flags_out[CFA_BIT_C] == $past(9'(opa_in[7:0]) + 9'(opb_in[7:0]) > 9'h0FF))
    else $error("add carry wrong");
  borrow_sub_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_SUB && size_in == CFA_SZ_BYTE
    |=> condition_flags_out[CFA_BIT_C] == $past(opa_in[7:0] < opb_in[7:0]))
    else $error("sub borrow wrong");
  shift_carry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_SHR |=> condition_flags_out[CFA_BIT_C] == $past(opa_in[0]))
    else $error("shift carry wrong");
  bit_load_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_BLD
    |=> condition_flags_out[CFA_BIT_C] == $past(opa_in[bit_idx_in]))
    else $error("bit load wrong");
  // Sign of the true 32-bit sum, not of the registered result
  neg_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_valid_in && op_in == CFA_OP_ADD && size_in == CFA_SZ_LONG
    |=> condition_flags_out[CFA_BIT_N] == $past((opa_in + opb_in) >= 32'h8000_0000))
    else $error("negative flag wrong");
  flags_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !op_valid_in |=> $stable(condition_flags_out)) else $error("flags changed idle");
  align_even_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mem_fetch_in || mem_size_in != CFA_SZ_BYTE) |-> !mem_addr_out[0])
    else $error("odd aligned address");
endmodule
`default_nettype wire

// ---- hdl/cfa_pkg.sv ----
// Constants and types for the flag and operand-alignment datapath
package cfa_pkg;
  localparam int CFA_CCR_W = 8;
  localparam int CFA_BIT_C = 0;
  localparam int CFA_BIT_V = 1;
  localparam int CFA_BIT_Z = 2;
  localparam int CFA_BIT_N = 3;
  localparam int CFA_BIT_H = 5;
  localparam int CFA_BIT_I = 7;
  localparam int CFA_HC_B = 3;
  localparam int CFA_HC_W = 11;
  localparam int CFA_HC_L = 27;
  localparam int CFA_NIB_W = 4;
  localparam int CFA_BIDX_W = 3;
  localparam int CFA_ADDR_W = 24;
  localparam logic [7:0] CFA_NIB_LIMIT = 8'h09;
  localparam logic [7:0] CFA_DEC_ADJ_LO = 8'h06;
  localparam logic [7:0] CFA_DEC_ADJ_HI = 8'h60;

  typedef enum logic [1:0] {
    CFA_SZ_BYTE = 2'h0,
    CFA_SZ_WORD = 2'h1,
    CFA_SZ_LONG = 2'h2
  } cfa_size_t;

  typedef enum logic [3:0] {
    CFA_OP_NONE = 4'h0,
    CFA_OP_ADD = 4'h1,
    CFA_OP_ADDX = 4'h2,
    CFA_OP_SUB = 4'h3,
    CFA_OP_SUBX = 4'h4,
    CFA_OP_AND = 4'h5,
    CFA_OP_SHL = 4'h6,
    CFA_OP_SHR = 4'h7,
    CFA_OP_ROTL = 4'h8,
    CFA_OP_ROTR = 4'h9,
    CFA_OP_BLD = 4'hA,
    CFA_OP_BST = 4'hB,
    CFA_OP_BAND = 4'hC,
    CFA_OP_DAA = 4'hD,
    CFA_OP_DAS = 4'hE,
    CFA_OP_LDC = 4'hF
  } cfa_op_t;
endpackage

// ---- hdl/cfa_align.sv ----
// Word and longword address alignment, also for instruction fetches
`timescale 1ns/100ps
`default_nettype none
module cfa_align
  import cfa_pkg::*;
#(
  parameter int ADDR_W = CFA_ADDR_W
) (
  // Request
  input wire logic [ADDR_W-1:0] addr_in,
  input wire cfa_size_t size_in,
  input wire logic fetch_in,
  // Aligned address, never faults
  output logic [ADDR_W-1:0] addr_out
);
  logic force_even;
  // Byte data accesses keep their odd address
  assign force_even = fetch_in || (size_in != CFA_SZ_BYTE);
  // No error path exists at all
  assign addr_out = {addr_in[ADDR_W-1:1], addr_in[0] & ~force_even};
endmodule
`default_nettype wire

// ---- sim/cpu_flags_and_operand_alignment_tb_top.sv ----
// Self-checking bench for the flag datapath and address alignment
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module cpu_flags_and_operand_alignment_tb_top;
  import cfa_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in;
  logic op_valid_in;
  cfa_op_t op_in;
  cfa_size_t size_in;
  logic [31:0] opa_in;
  logic [31:0] opb_in;
  logic [CFA_BIDX_W-1:0] bit_idx_in;
  logic [CFA_CCR_W-1:0] ccr_wdata_in;
  logic [CFA_ADDR_W-1:0] mem_addr_in;
  cfa_size_t mem_size_in;
  logic mem_fetch_in;
  logic [CFA_ADDR_W-1:0] mem_addr_out;
  logic [31:0] result_out;
  logic [CFA_CCR_W-1:0] f;
  logic [31:0] mem_bytes_out;
  logic [4:0] hnzvc;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  cfa_op_t sh_op [4] = '{CFA_OP_SHL, CFA_OP_SHR, CFA_OP_ROTL, CFA_OP_ROTR};
  logic [7:0] sh_a [4] = '{8'h80, 8'h01, 8'h81, 8'h01};
  logic [7:0] sh_r [4] = '{8'h00, 8'h00, 8'h03, 8'h80};
  logic [CFA_ADDR_W-1:0] al_a [4] = '{24'h000001, 24'h123457, 24'h000003, 24'h000005};
  logic [CFA_ADDR_W-1:0] al_e [4] = '{24'h000000, 24'h123456, 24'h000003, 24'h000004};
  cfa_size_t al_s [4] = '{CFA_SZ_WORD, CFA_SZ_LONG, CFA_SZ_BYTE, CFA_SZ_BYTE};
  logic al_f [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  assign hnzvc = {f[CFA_BIT_H], f[CFA_BIT_N], f[CFA_BIT_Z], f[CFA_BIT_V], f[CFA_BIT_C]};

  cfa_flags cfa_flags_inst (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .op_valid_in(op_valid_in),
    .op_in(op_in),
    .size_in(size_in),
    .opa_in(opa_in),
    .opb_in(opb_in),
    .bit_idx_in(bit_idx_in),
    .ccr_wdata_in(ccr_wdata_in),
    .mem_addr_in(mem_addr_in),
    .mem_size_in(mem_size_in),
    .mem_fetch_in(mem_fetch_in),
    .mem_addr_out(mem_addr_out),
    .result_out(result_out),
    .condition_flags_out(f),
    .mem_bytes_out(mem_bytes_out)
  );

  always #25 clk_in = ~clk_in;

  // Whole run is a few dozen ops; far above that means a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One op taken at a rising edge, then an idle cycle so valid is not re-driven
  task automatic run(input cfa_op_t o, input cfa_size_t s, input logic [31:0] a,
                     input logic [31:0] b, input logic [2:0] i);
    op_in = o;
    size_in = s;
    opa_in = a;
    opb_in = b;
    bit_idx_in = i;
    op_valid_in = 1'b1;
    @(negedge clk_in);
    op_valid_in = 1'b0;
    @(negedge clk_in);
  endtask

  initial begin
    resetn_in = 1'b0;
    op_valid_in = 1'b0;
    op_in = CFA_OP_NONE;
    size_in = CFA_SZ_BYTE;
    opa_in = 32'h0;
    opb_in = 32'h0;
    bit_idx_in = 3'h0;
    ccr_wdata_in = 8'h00;
    mem_addr_in = 24'h000000;
    mem_size_in = CFA_SZ_BYTE;
    mem_fetch_in = 1'b0;
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    `CHK("mask", 1'b1, f[CFA_BIT_I])
    // Flags are undefined after reset; load them before any idle cycle
    ccr_wdata_in = 8'h80;
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    $display("test reset done");

    run(CFA_OP_ADD, CFA_SZ_BYTE, 32'hFF, 32'h01, 3'h0);
    `CHK("add_b", 8'h00, result_out[7:0])
    `CHK("add_b hnzvc", 5'b10101, hnzvc)
    run(CFA_OP_ADD, CFA_SZ_BYTE, 32'h7F, 32'h01, 3'h0);
    `CHK("ovf hnzvc", 5'b11010, hnzvc)
    run(CFA_OP_SUB, CFA_SZ_BYTE, 32'h00, 32'h01, 3'h0);
    `CHK("sub_b", 8'hFF, result_out[7:0])
    `CHK("sub_b hnzvc", 5'b11001, hnzvc)
    run(CFA_OP_SUB, CFA_SZ_WORD, 32'h8000, 32'h0001, 3'h0);
    `CHK("sub_w", 16'h7FFF, result_out[15:0])
    `CHK("sub_w hnzvc", 5'b10010, hnzvc)
    run(CFA_OP_ADD, CFA_SZ_LONG, 32'h0FFFFFFF, 32'h1, 3'h0);
    `CHK("add_l", 32'h10000000, result_out)
    `CHK("add_l hnzvc", 5'b10000, hnzvc)
    run(CFA_OP_ADD, CFA_SZ_WORD, 32'h1234, 32'h0, 3'h0);
    `CHK("lanes_w", 16'h1234, mem_bytes_out[31:16])
    `CHK("add_w hnzvc", 5'b00000, hnzvc)
    $display("test arith done");

    for (int k = 0; k < 4; k++) begin
      run(sh_op[k], CFA_SZ_BYTE, {24'h0, sh_a[k]}, 32'h0, 3'h0);
      `CHK("shift", sh_r[k], result_out[7:0])
      `CHK("shift c", 1'b1, f[CFA_BIT_C])
    end
    $display("test shift done");

    ccr_wdata_in = 8'h80;
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    run(CFA_OP_BLD, CFA_SZ_BYTE, 32'h20, 32'h0, 3'h5);
    `CHK("bld", 8'h81, f)
    run(CFA_OP_BAND, CFA_SZ_BYTE, 32'h20, 32'h0, 3'h4);
    `CHK("band", 8'h80, f)
    run(CFA_OP_BLD, CFA_SZ_BYTE, 32'h80, 32'h0, 3'h7);
    run(CFA_OP_BST, CFA_SZ_BYTE, 32'h00, 32'h0, 3'h7);
    `CHK("bst", 8'h80, result_out[7:0])
    `CHK("bst c", 8'h81, f)
    $display("test bit done");

    ccr_wdata_in = 8'h00;
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    run(CFA_OP_ADD, CFA_SZ_BYTE, 32'h09, 32'h01, 3'h0);
    run(CFA_OP_DAA, CFA_SZ_BYTE, 32'h0A, 32'h0, 3'h0);
    `CHK("daa", 8'h10, result_out[7:0])
    run(CFA_OP_SUB, CFA_SZ_BYTE, 32'h10, 32'h01, 3'h0);
    run(CFA_OP_DAS, CFA_SZ_BYTE, 32'h0F, 32'h0, 3'h0);
    `CHK("das", 8'h09, result_out[7:0])
    ccr_wdata_in = 8'hA5;
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    `CHK("ldc", 8'hA5, f)
    run(CFA_OP_NONE, CFA_SZ_BYTE, 32'hFF, 32'h1, 3'h0);
    `CHK("keep", 8'hA5, f)
    $display("test decimal done");

    ccr_wdata_in = 8'h01;
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    run(CFA_OP_ADDX, CFA_SZ_BYTE, 32'h10, 32'h01, 3'h0);
    `CHK("addx", 8'h12, result_out[7:0])
    `CHK("addx hnzvc", 5'b00000, hnzvc)
    run(CFA_OP_LDC, CFA_SZ_BYTE, 32'h0, 32'h0, 3'h0);
    run(CFA_OP_SUBX, CFA_SZ_BYTE, 32'h10, 32'h01, 3'h0);
    `CHK("subx", 8'h0E, result_out[7:0])
    `CHK("subx hnzvc", 5'b10000, hnzvc)
    run(CFA_OP_AND, CFA_SZ_BYTE, 32'hF0, 32'h0F, 3'h0);
    `CHK("and hnzvc", 5'b10100, hnzvc)
    run(CFA_OP_ADD, CFA_SZ_BYTE, 32'hAB, 32'h0, 3'h0);
    `CHK("lanes_b", 32'hAB00_0000, mem_bytes_out)
    run(CFA_OP_ADD, CFA_SZ_LONG, 32'h8122_3344, 32'h0, 3'h0);
    `CHK("lanes_l", 32'h8122_3344, mem_bytes_out)
    `CHK("add_l n", 1'b1, f[CFA_BIT_N])
    $display("test carry chain done");

    for (int k = 0; k < 4; k++) begin
      mem_addr_in = al_a[k];
      mem_size_in = al_s[k];
      mem_fetch_in = al_f[k];
      #1;
      `CHK("align", al_e[k], mem_addr_out)
      @(negedge clk_in);
    end
    // Stack accesses are word sized, so an odd stack address is aligned
    mem_addr_in = 24'h00FFFF;
    mem_size_in = CFA_SZ_WORD;
    mem_fetch_in = 1'b0;
    #1;
    `CHK("stack", 24'h00FFFE, mem_addr_out)
    $display("test align done");
    stop_test();
  end
endmodule
`default_nettype wire
